// *** lbc_pkg.sv ***
package lbc_pkg;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned NUM_HOLES   = 2;
  localparam int unsigned CLAIM_WIN   = 2;
  localparam int unsigned ISA_CYCLES  = 6;
  localparam logic [2:0]  CNT_W3      = 3'h0;
  localparam logic        SPACE_IO    = 1'b1;
  localparam logic        SPACE_MEM   = 1'b0;

  typedef enum logic [2:0] {
    LBC_IDLE  = 3'b000,
    LBC_CLAIM = 3'b001,
    LBC_LOCAL = 3'b010,
    LBC_ISA   = 3'b011,
    LBC_DONE  = 3'b100
  } lbc_state_t;
endpackage : lbc_pkg

// *** lbc_cycle_claim.sv ***
`timescale 1ns/1ns
// Operation
// - With no local claim, this block answers the processor cycle and ends it.
// - Claiming devices pull local_claim_n low; it is sampled during the claim window.
// - Two programmable decode holes, each selecting the I/O or the memory space.
// - A processor cycle address inside an enabled hole is ignored entirely by this block; DMA cycles are never checked against the holes.
// - During DMA this block drives local address and control like the processor.
// - DMA cycle information goes to local bus and backplane; the backplane cycle starts one clock after the local bus drive.
// - An unclaimed DMA cycle is completed with backplane timing.
module lbc_cycle_claim
  import lbc_pkg::*;
#(
  parameter int unsigned CLAIM_CYCLES = lbc_pkg::CLAIM_WIN,
  parameter int unsigned ISA_LEN      = lbc_pkg::ISA_CYCLES
) (
  // Clock and reset.
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  // Processor cycle request.
  input  wire logic                      i_cyc_start,
  input  wire logic                      i_cyc_io,
  input  wire logic [lbc_pkg::ADDR_W-1:0] i_cyc_addr,
  input  wire logic                      i_local_claim_n,
  // DMA request.
  input  wire logic                      i_dma_start,
  input  wire logic                      i_dma_io,
  input  wire logic [lbc_pkg::ADDR_W-1:0] i_dma_addr,
  // Decode hole setup, one bit or word per hole.
  input  wire logic [lbc_pkg::NUM_HOLES-1:0]               i_hole_en,
  input  wire logic [lbc_pkg::NUM_HOLES-1:0]               i_hole_io,
  input  wire logic [lbc_pkg::NUM_HOLES*lbc_pkg::ADDR_W-1:0] i_hole_base,
  input  wire logic [lbc_pkg::NUM_HOLES*lbc_pkg::ADDR_W-1:0] i_hole_size,
  // Local bus drive during DMA.
  output logic                           o_lb_drive,
  output logic [lbc_pkg::ADDR_W-1:0]     o_lb_addr,
  output logic                           o_lb_io,
  // Backplane cycle.
  output logic                           o_isa_cyc,
  output logic [lbc_pkg::ADDR_W-1:0]     o_isa_addr,
  // Cycle termination and status.
  output logic                           o_ready,
  output logic                           o_busy
);
  import lbc_pkg::*;

  logic       rst_s1;
  logic       rst_n;
  logic       claim_s1;
  logic       claim_s2;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // The claim pin is asynchronous to us, so only the second stage is looked at.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      claim_s1 <= 1'b1;
      claim_s2 <= 1'b1;
    end else begin
      claim_s1 <= i_local_claim_n;
      claim_s2 <= claim_s1;
    end
  end

  function automatic logic hole_hit(input logic io, input logic [ADDR_W-1:0] addr);
    logic hit;
    logic [ADDR_W-1:0] b;
    logic [ADDR_W-1:0] s;
    hit = 1'b0;
    for (int i = 0; i < NUM_HOLES; i++) begin
      b = i_hole_base[i*ADDR_W +: ADDR_W];
      s = i_hole_size[i*ADDR_W +: ADDR_W];
      if (i_hole_en[i] && (i_hole_io[i] == io) && (addr >= b) && ((addr - b) < s)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : hole_hit

  lbc_state_t              state;
  lbc_state_t              next_state;
  logic [7:0]              cnt;
  logic [7:0]              next_cnt;
  logic                    dma;
  logic                    next_dma;
  logic [ADDR_W-1:0]       addr;
  logic [ADDR_W-1:0]       next_addr;
  logic                    io;
  logic                    next_io;
  logic                    next_ready;
  logic                    next_isa;

  localparam logic [7:0] CLAIM_LAST = 8'(CLAIM_CYCLES - 1);
  localparam logic [7:0] ISA_LAST   = 8'(ISA_LEN - 1);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_dma   = dma;
    next_addr  = addr;
    next_io    = io;
    next_ready = 1'b0;
    next_isa   = 1'b0;
    case (state)
      LBC_IDLE: begin
        next_cnt = 8'h00;
        if (i_dma_start) begin
          next_dma   = 1'b1;
          next_addr  = i_dma_addr;
          next_io    = i_dma_io;
          next_state = LBC_CLAIM;
        end else if (i_cyc_start && !hole_hit(i_cyc_io, i_cyc_addr)) begin
          next_dma   = 1'b0;
          next_addr  = i_cyc_addr;
          next_io    = i_cyc_io;
          next_state = LBC_CLAIM;
        end
      end
      LBC_CLAIM: begin
        // The pin passes two flops, so a claim must stand at the edge that takes the cycle.
        // A wider window would admit slower claimers at the cost of backplane latency.
        next_isa = dma;
        if (!claim_s2) begin
          next_state = LBC_LOCAL;
        end else if (cnt == CLAIM_LAST) begin
          next_cnt   = 8'h00;
          next_isa   = 1'b1;
          next_state = LBC_ISA;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      LBC_LOCAL: begin
        // The claiming device ends its own cycle; wait for it to release.
        next_isa = dma;
        if (claim_s2) begin
          next_state = LBC_IDLE;
          next_dma   = 1'b0;
        end
      end
      LBC_ISA: begin
        next_isa = 1'b1;
        if (cnt == ISA_LAST) begin
          next_isa   = 1'b0;
          next_ready = 1'b1;
          next_state = LBC_DONE;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      LBC_DONE: begin
        next_dma   = 1'b0;
        next_state = LBC_IDLE;
      end
      default: next_state = LBC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= LBC_IDLE;
      cnt        <= 8'h00;
      dma        <= 1'b0;
      addr       <= '0;
      io         <= 1'b0;
      o_ready    <= 1'b0;
      o_isa_cyc  <= 1'b0;
      o_lb_drive <= 1'b0;
      o_lb_addr  <= '0;
      o_lb_io    <= 1'b0;
      o_isa_addr <= '0;
      o_busy     <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      dma        <= next_dma;
      addr       <= next_addr;
      io         <= next_io;
      o_ready    <= next_ready;
      o_isa_cyc  <= next_isa;
      o_lb_drive <= next_dma && (next_state != LBC_IDLE);
      o_lb_addr  <= next_addr;
      o_lb_io    <= next_io;
      o_isa_addr <= next_addr;
      o_busy     <= (next_state != LBC_IDLE);
    end
  end

  hole_ignore_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (state == LBC_IDLE && i_cyc_start && !i_dma_start && hole_hit(i_cyc_io, i_cyc_addr))
      |=> (state == LBC_IDLE))
    else $error("Cycle in a decode hole was taken.");
  default_term_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (state == LBC_ISA && !dma) |-> ##[1:64] o_ready)
    else $error("Unclaimed cycle was not terminated.");
  claim_backoff_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (state == LBC_CLAIM && !claim_s2) |=> (state == LBC_LOCAL))
    else $error("Claimed cycle was not left to the claimer.");
  local_noready_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (state == LBC_LOCAL) |=> !o_ready)
    else $error("Ready driven on a claimed cycle.");
  dma_drive_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (dma && state == LBC_CLAIM) |-> o_lb_drive)
    else $error("Local bus not driven during DMA.");
  dma_both_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (dma && state == LBC_CLAIM && $past(state) == LBC_CLAIM) |-> (o_isa_cyc && o_isa_addr == o_lb_addr))
    else $error("DMA cycle not on both buses.");
  dma_isa_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (dma && state == LBC_CLAIM && claim_s2 && cnt == CLAIM_LAST) |=> (state == LBC_ISA))
    else $error("Unclaimed DMA cycle not sent to backplane.");
  hole_range_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_hole_en == 2'h0) |-> !hole_hit(i_cyc_io, i_cyc_addr))
    else $error("Disabled hole matched.");
endmodule : lbc_cycle_claim

// *** lbc_claim_dev.sv ***
`timescale 1ns/1ns
// Local device that claims chosen cycles; its claim line idles high as if pulled up.
module lbc_claim_dev (
  // Clock and request.
  input  wire logic i_core_clk,
  input  wire logic i_start,
  input  wire logic i_want,
  // Claim output.
  output logic      o_local_claim_n
);
  int cnt = 0;
  always_ff @(posedge i_core_clk) begin
    if (i_start && i_want) cnt <= 6;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // The claim follows the request at once, so it already stands when the cycle is taken.
  assign o_local_claim_n = !((i_start && i_want) || (cnt > 0));
endmodule : lbc_claim_dev

// *** tb_lbc_cycle_claim.sv ***
`timescale 1ns/1ns
module tb_lbc_cycle_claim;
  import lbc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, cs = 1'b0, cio = 1'b0, ds = 1'b0, dio = 1'b0, want = 1'b0;
  logic [ADDR_W-1:0] ca = '0, da = '0, la, ia;
  logic [NUM_HOLES-1:0] hen = '0, hio = '0;
  logic [NUM_HOLES*ADDR_W-1:0] hb = '0, hs = '0;
  logic cl_n, drv, lio, isa, rdy, busy;
  int err_total = 0, comparisons = 0;
  logic [31:0] rng = 32'h00000061;
  logic [31:0] cor [8] = '{32'h300, 32'h30F, 32'h310, 32'h300, 32'hD0000, 32'hDFFFF,
                           32'hE0000, 32'h300};
  initial forever #20 clk = ~clk;
  lbc_claim_dev u_lbc_claim_dev (.i_core_clk(clk), .i_start(cs || ds), .i_want(want),
    .o_local_claim_n(cl_n));
  lbc_cycle_claim u_lbc_cycle_claim (.i_core_clk(clk), .i_nrst(nrst), .i_cyc_start(cs),
    .i_cyc_io(cio), .i_cyc_addr(ca), .i_local_claim_n(cl_n), .i_dma_start(ds),
    .i_dma_io(dio), .i_dma_addr(da), .i_hole_en(hen), .i_hole_io(hio), .i_hole_base(hb),
    .i_hole_size(hs), .o_lb_drive(drv), .o_lb_addr(la), .o_lb_io(lio), .o_isa_cyc(isa),
    .o_isa_addr(ia), .o_ready(rdy), .o_busy(busy));
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic hit(input logic io, input logic [31:0] a);
    hit = 1'b0;
    for (int h = 0; h < NUM_HOLES; h++)
      if (hen[h] && hio[h] == io && a >= hb[h*ADDR_W+:ADDR_W]
          && a - hb[h*ADDR_W+:ADDR_W] < hs[h*ADDR_W+:ADDR_W]) hit = 1'b1;
  endfunction : hit
  task automatic run(input logic dma, input logic io, input logic w, input logic [31:0] a);
    logic ign, g_busy, g_rdy, g_drv, g_both, g_isa;
    logic [32:0] lb_seen;
    logic [31:0] isa_seen;
    ign = !dma && hit(io, a);
    g_busy = 1'b0; g_rdy = 1'b0; g_drv = 1'b0; g_both = 1'b0;
    g_isa = 1'b0;
    // Start from the inverse wherever the bus must show the cycle, so a silent bus fails.
    lb_seen = dma ? ~{io, a} : {io, a};
    isa_seen = (dma || !(ign || w)) ? ~a : a;
    want = w;
    if (dma) begin ds = 1'b1; dio = io; da = a; end
    else begin cs = 1'b1; cio = io; ca = a; end
    @(posedge clk); #2;
    ds = 1'b0; cs = 1'b0;
    // Fixed span covers the full backplane length and a claim held by the local device.
    for (int k = 0; k < 30; k++) begin
      g_busy |= busy; g_rdy |= rdy; g_drv |= drv; g_both |= drv && isa;
      g_isa |= isa;
      if (drv) lb_seen = {lio, la};
      if (isa) isa_seen = ia;
      @(posedge clk); #2;
    end
    chk(g_busy, !ign);
    chk(g_rdy, !ign && !w);
    chk(g_isa, dma || (!ign && !w));
    chk(g_drv, dma);
    chk(g_both, dma);
    chk(lb_seen, {io, a});
    chk(isa_seen, a);
    chk(busy, 1'b0);
    if (busy !== 1'b0) close_out();
  endtask : run
  initial begin
    repeat (20) @(posedge clk);
    #2 nrst = 1'b1;
    repeat (5) @(posedge clk);
    #2 hen = 2'h3; hio = 2'h1;
    hb = {32'h000D0000, 32'h00000300}; hs = {32'h00010000, 32'h00000010};
    for (int i = 0; i < 8; i++) run(i == 7, i < 3 || i == 7, 1'b0, cor[i]);
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      hen = rng[9:8];
      run(rng[0], rng[1], rng[2], rng[3] ? rng : cor[rng[6:4]] + rng[10]);
    end
    close_out();
  end
endmodule : tb_lbc_cycle_claim
